// file: verilog/rtc_params.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  real-time clock flag and time-counter block.
  Assumes a 25 MHz system clock and a 32.768 kHz crystal clock on a pin.
*/
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define RTC_ADDR_SECONDS 4'h0
`define RTC_ADDR_MINUTES 4'h1
`define RTC_ADDR_HOURS 4'h2
`define RTC_ADDR_ADJUST 4'h7
`define RTC_ADDR_CTRL1 4'hE
`define RTC_ADDR_CTRL2 4'hF

// ----------------------------------------------------------------------
// Control register 1 fields
// ----------------------------------------------------------------------
`define RTC_C1_WEEKLY_ALARM_ENABLE 7
`define RTC_C1_DAILY_ALARM_ENABLE 6
`define RTC_C1_MODE24 5
`define RTC_C1_CLKOUT_DISABLE_B 4
`define RTC_C1_TEST 3
`define RTC_C1_CT_HI 2

// ----------------------------------------------------------------------
// Control register 2 fields
// ----------------------------------------------------------------------
`define RTC_C2_VDSL 7
`define RTC_C2_VDET 6
`define RTC_C2_XST 5
`define RTC_C2_PON 4
`define RTC_C2_CLKOUT_DISABLE_A 3
`define RTC_C2_PERIODIC_IRQ_FLAG 2
`define RTC_C2_WEEKLY_ALARM_FLAG 1
`define RTC_C2_DAILY_ALARM_FLAG 0

// ----------------------------------------------------------------------
// Reset values and counter limits
// ----------------------------------------------------------------------
`define RTC_BYTE_RESET 8'h00
`define RTC_PRESCALE_MAX 15'h7FFF
`define RTC_BCD_59 7'h59
`define RTC_HOUR_23 6'h23
`define RTC_HOUR_12 5'h12
`define RTC_HOUR_11 5'h11
`define RTC_PULSE_2HZ_BIT 13
`define RTC_PULSE_1HZ_BIT 14

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RTC_CLK_HZ 25000000
`define RTC_ALARM_DELAY_US 61
`define RTC_ALARM_DELAY_CYCLES \
  ((`RTC_ALARM_DELAY_US * `RTC_CLK_HZ) / 1000000)

// Serial bus device address, value arbitrary
`define RTC_DEV_ADDR 7'h51

`endif

// file: verilog/rtc_types_pkg.sv
/*
  Types shared by the real-time clock block and its serial register port.
  Assumes nothing of its surroundings.
*/
package rtc_types_pkg;
  typedef enum logic [2:0] {
    st_idle, st_addr, st_ptr, st_wdata, st_rdata, st_mack, st_rload
  } serial_state_type;

  typedef enum logic [2:0] {
    ct_off, ct_low, ct_2hz, ct_1hz, ct_sec, ct_min, ct_hour, ct_month
  } periodic_mode_type;
endpackage

// file: verilog/serial_reg_port.sv
/*
  Two-wire serial slave that turns bus transfers into register reads and
  writes: address byte, register pointer byte, then data bytes with an
  auto-incrementing pointer.
  Assumes scl and sda arrive as pins from another domain; the wire level is
  resolved outside from sda_oe.
*/
`timescale 1ns/1ns
`default_nettype none
`include "rtc_params.svh"

module serial_reg_port import rtc_types_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic [3:0] reg_addr,
  output logic [7:0] wr_data,
  output logic wr_pulse,
  output logic start_pulse,
  input wire logic [7:0] rd_data
);
  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  serial_state_type state, next_state;
  logic [3:0] bit_cnt, next_bit_cnt, ptr, next_ptr;
  logic [7:0] shreg, next_shreg;
  logic rw, next_rw, acking, next_acking, oe, next_oe;

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  always_ff @(posedge clk) begin
    scl_s1 <= scl_in;
    scl_s2 <= scl_s1;
    scl_d <= scl_s2;
    sda_s1 <= sda_in;
    sda_s2 <= sda_s1;
    sda_d <= sda_s2;
  end

  assign scl_rise = scl_s2 & ~scl_d;
  assign scl_fall = ~scl_s2 & scl_d;
  assign start_cond = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop_cond = scl_s2 & scl_d & ~sda_d & sda_s2;

  // --------------------------------------------------------------------
  // Byte engine
  // --------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_ptr = ptr;
    next_shreg = shreg;
    next_rw = rw;
    next_acking = acking;
    next_oe = oe;
    wr_pulse = 1'b0;
    if (start_cond) begin
      next_state = st_addr;
      next_bit_cnt = 4'h0;
      next_acking = 1'b0;
      next_oe = 1'b0;
    end else if (stop_cond) begin
      next_state = st_idle;
      next_acking = 1'b0;
      next_oe = 1'b0;
    end else begin
      case (state)
        st_addr, st_ptr, st_wdata: begin
          if (scl_rise && bit_cnt < 4'h8) begin
            next_shreg = {shreg[6:0], sda_s2};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8 && !acking) begin
            if (state == st_addr && shreg[7:1] != `RTC_DEV_ADDR) begin
              next_state = st_idle;
            end else begin
              next_acking = 1'b1;
              next_oe = 1'b1;
              wr_pulse = (state == st_wdata);
              if (state == st_addr) next_rw = shreg[0];
              if (state == st_ptr) next_ptr = shreg[3:0];
            end
          end else if (scl_fall && bit_cnt == 4'h8) begin
            next_acking = 1'b0;
            next_oe = 1'b0;
            next_bit_cnt = 4'h0;
            if (state == st_addr && rw) begin
              next_state = st_rdata;
              next_shreg = rd_data;
              next_oe = ~rd_data[7];
            end else if (state == st_addr) begin
              next_state = st_ptr;
            end else if (state == st_ptr) begin
              next_state = st_wdata;
            end else begin
              next_ptr = ptr + 4'h1;
            end
          end
        end
        st_rdata: begin
          if (scl_rise && bit_cnt < 4'h8) begin
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            next_oe = 1'b0;
            next_state = st_mack;
          end else if (scl_fall) begin
            next_shreg = {shreg[6:0], 1'b0};
            next_oe = ~shreg[6];
          end
        end
        st_mack: begin
          if (scl_rise && sda_s2) begin
            next_state = st_idle;
          end else if (scl_rise) begin
            next_ptr = ptr + 4'h1;
            next_state = st_rload;
          end
        end
        st_rload: begin
          if (scl_fall) begin
            next_state = st_rdata;
            next_bit_cnt = 4'h0;
            next_shreg = rd_data;
            next_oe = ~rd_data[7];
          end
        end
        default: next_state = st_idle;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= st_idle;
      bit_cnt <= 4'h0;
      ptr <= 4'h0;
      shreg <= `RTC_BYTE_RESET;
      rw <= 1'b0;
      acking <= 1'b0;
      oe <= 1'b0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      ptr <= next_ptr;
      shreg <= next_shreg;
      rw <= next_rw;
      acking <= next_acking;
      oe <= next_oe;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = oe;
  assign reg_addr = ptr;
  assign wr_data = shreg;
  assign start_pulse = start_cond;
endmodule // serial_reg_port

`default_nettype wire

// file: verilog/rtc_flags_and_time_counters.sv
/*
  Power-on flag, clock-output gating, periodic and alarm interrupt flags,
  and the seconds, minutes and hours BCD counters of a real-time clock.
  Assumes a 25 MHz clk, the crystal clock on xtal_in, alarm compare results
  from same-clock logic, and a host on the two-wire serial bus.
*/
`timescale 1ns/1ns
`default_nettype none
`include "rtc_params.svh"

module rtc_flags_and_time_counters import rtc_types_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic xtal_in,
  input wire logic weekly_alarm_match,
  input wire logic daily_alarm_match,
  output logic slow_clock_out,
  output logic irq_pin_a_n,
  output logic irq_pin_b_n,
  output logic day_carry
);
  logic [3:0] reg_addr;
  logic [7:0] wr_data, rd_data;
  logic wr_pulse, start_pulse;
  logic xtal_s1, xtal_s2, xtal_d;
  logic tick, sec_inc, min_inc, hour_ev, day_c, period_ev, periodic_active;
  logic pon_hold, level_mode;
  logic [6:0] hour_calc;
  logic [14:0] prescaler, next_prescaler;
  logic [6:0] seconds, next_seconds, minutes, next_minutes;
  logic [5:0] hours, next_hours;
  logic [6:0] snap_sec, next_snap_sec, snap_min, next_snap_min;
  logic [5:0] snap_hour, next_snap_hour;
  logic [6:0] adjust, next_adjust;
  logic [7:0] ctrl1, next_ctrl1;
  logic power_up_flag, next_power_up_flag;
  logic osc_halt_monitor_n, next_osc_halt_monitor_n;
  logic vdsl, next_vdsl, vdet, next_vdet;
  logic clkout_disable_a, next_clkout_disable_a;
  logic level_flag, next_level_flag;
  logic weekly_alarm_flag, next_weekly_alarm_flag;
  logic daily_alarm_flag, next_daily_alarm_flag;
  logic next_slow_clock_out, next_day_carry;
  logic weekly_alarm_enable, daily_alarm_enable, clkout_disable_b;
  logic mode24;
  periodic_mode_type ct_mode;
  logic [1:0] alarm_match, alarm_en, alarm_hit;

  serial_reg_port u_port (
    .clk(clk),
    .nrst(nrst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .reg_addr(reg_addr),
    .wr_data(wr_data),
    .wr_pulse(wr_pulse),
    .start_pulse(start_pulse),
    .rd_data(rd_data)
  );

  assign weekly_alarm_enable = ctrl1[`RTC_C1_WEEKLY_ALARM_ENABLE];
  assign daily_alarm_enable = ctrl1[`RTC_C1_DAILY_ALARM_ENABLE];
  assign mode24 = ctrl1[`RTC_C1_MODE24];
  assign clkout_disable_b = ctrl1[`RTC_C1_CLKOUT_DISABLE_B];
  assign ct_mode = periodic_mode_type'(ctrl1[`RTC_C1_CT_HI:0]);
  assign level_mode = ctrl1[`RTC_C1_CT_HI];

  // --------------------------------------------------------------------
  // BCD helpers
  // --------------------------------------------------------------------
  function automatic logic [6:0] bcd_inc60(input logic [6:0] v);
    if (v == `RTC_BCD_59) bcd_inc60 = 7'h00;
    else if (v[3:0] == 4'h9) bcd_inc60 = {v[6:4] + 3'h1, 4'h0};
    else bcd_inc60 = {v[6:4], v[3:0] + 4'h1};
  endfunction

  // Returns {day carry, next hour}
  function automatic logic [6:0] hour_inc(input logic [5:0] h,
                                          input logic m24);
    if (m24 && h == `RTC_HOUR_23) hour_inc = 7'h40;
    else if (m24 && h[3:0] == 4'h9) hour_inc = {1'b0, h[5:4] + 2'h1, 4'h0};
    else if (m24) hour_inc = {1'b0, h[5:4], h[3:0] + 4'h1};
    else if (h[4:0] == `RTC_HOUR_12) hour_inc = {1'b0, h[5], 5'h01};
    else if (h[4:0] == `RTC_HOUR_11) hour_inc = {h[5], ~h[5], `RTC_HOUR_12};
    else if (h[3:0] == 4'h9) hour_inc = {1'b0, h[5], 1'b1, 4'h0};
    else hour_inc = {1'b0, h[5], h[4], h[3:0] + 4'h1};
  endfunction

  // --------------------------------------------------------------------
  // Crystal synchroniser
  // --------------------------------------------------------------------
  always_ff @(posedge clk) begin
    xtal_s1 <= xtal_in;
    xtal_s2 <= xtal_s1;
    xtal_d <= xtal_s2;
  end

  // --------------------------------------------------------------------
  // Alarm match delay, one per alarm
  // --------------------------------------------------------------------
  assign alarm_match = {daily_alarm_match, weekly_alarm_match};
  assign alarm_en = {daily_alarm_enable, weekly_alarm_enable};

  for (genvar i = 0; i < 2; i++) begin : g_alarm
    logic [10:0] dly, next_dly;
    logic md, hit;
    always_comb begin
      next_dly = dly;
      hit = 1'b0;
      if (!alarm_en[i]) next_dly = 11'h000;
      else if (alarm_match[i] && !md)
        next_dly = 11'(`RTC_ALARM_DELAY_CYCLES);
      else if (dly == 11'h001) begin
        hit = 1'b1;
        next_dly = 11'h000;
      end else if (dly != 11'h000) next_dly = dly - 11'h001;
    end
    always_ff @(posedge clk) begin
      if (!nrst) begin
        dly <= 11'h000;
        md <= 1'b0;
      end else begin
        dly <= next_dly;
        md <= alarm_match[i];
      end
    end
    assign alarm_hit[i] = hit;
  end

  // --------------------------------------------------------------------
  // Periodic output and register read
  // --------------------------------------------------------------------
  always_comb begin
    case (ct_mode)
      ct_low: periodic_active = 1'b1;
      ct_2hz: periodic_active = ~prescaler[`RTC_PULSE_2HZ_BIT];
      ct_1hz: periodic_active = ~prescaler[`RTC_PULSE_1HZ_BIT];
      ct_sec, ct_min, ct_hour, ct_month: periodic_active = level_flag;
      default: periodic_active = 1'b0;
    endcase
  end

  always_comb begin
    case (reg_addr)
      `RTC_ADDR_SECONDS: rd_data = {1'b0, snap_sec};
      `RTC_ADDR_MINUTES: rd_data = {1'b0, snap_min};
      `RTC_ADDR_HOURS: rd_data = {2'b00, snap_hour};
      `RTC_ADDR_ADJUST: rd_data = {1'b0, adjust};
      `RTC_ADDR_CTRL1: rd_data = ctrl1;
      `RTC_ADDR_CTRL2: rd_data = {vdsl, vdet, osc_halt_monitor_n,
        power_up_flag, clkout_disable_a, periodic_active,
        weekly_alarm_flag & weekly_alarm_enable,
        daily_alarm_flag & daily_alarm_enable};
      default: rd_data = `RTC_BYTE_RESET;
    endcase
  end

  // Pins follow the flags combinationally so flag and pin never disagree
  assign irq_pin_a_n = ~(periodic_active |
    (daily_alarm_flag & daily_alarm_enable));
  assign irq_pin_b_n = ~(weekly_alarm_flag & weekly_alarm_enable);

  // --------------------------------------------------------------------
  // Counters, flags and registers
  // --------------------------------------------------------------------
  assign tick = xtal_s2 & ~xtal_d;
  assign sec_inc = tick && prescaler == `RTC_PRESCALE_MAX;
  assign min_inc = sec_inc && seconds == `RTC_BCD_59;
  assign hour_ev = min_inc && minutes == `RTC_BCD_59;
  assign hour_calc = hour_inc(hours, mode24);
  assign day_c = hour_calc[6];
  assign pon_hold = power_up_flag &&
    !(wr_pulse && reg_addr == `RTC_ADDR_CTRL2 && !wr_data[`RTC_C2_PON]);

  always_comb begin
    case (ct_mode)
      ct_sec: period_ev = sec_inc;
      ct_min: period_ev = min_inc;
      ct_hour: period_ev = hour_ev;
      ct_month: period_ev = hour_ev && day_c;
      default: period_ev = 1'b0;
    endcase
  end

  always_comb begin
    next_prescaler = tick ? prescaler + 15'h0001 : prescaler;
    next_seconds = sec_inc ? bcd_inc60(seconds) : seconds;
    next_minutes = min_inc ? bcd_inc60(minutes) : minutes;
    next_hours = hour_ev ? hour_calc[5:0] : hours;
    next_day_carry = hour_ev && day_c;
    next_snap_sec = start_pulse ? seconds : snap_sec;
    next_snap_min = start_pulse ? minutes : snap_min;
    next_snap_hour = start_pulse ? hours : snap_hour;
    next_adjust = adjust;
    next_ctrl1 = ctrl1;
    next_power_up_flag = power_up_flag;
    next_osc_halt_monitor_n = osc_halt_monitor_n;
    next_vdsl = vdsl;
    next_vdet = vdet;
    next_clkout_disable_a = clkout_disable_a;
    next_level_flag = level_flag;
    next_weekly_alarm_flag = weekly_alarm_flag;
    next_daily_alarm_flag = daily_alarm_flag;
    if (wr_pulse) begin
      case (reg_addr)
        `RTC_ADDR_SECONDS: begin
          next_seconds = wr_data[6:0];
          next_prescaler = 15'h0000;
        end
        `RTC_ADDR_MINUTES: next_minutes = wr_data[6:0];
        `RTC_ADDR_HOURS: next_hours = wr_data[5:0];
        `RTC_ADDR_ADJUST: next_adjust = wr_data[6:0];
        `RTC_ADDR_CTRL1: next_ctrl1 = wr_data;
        `RTC_ADDR_CTRL2: begin
          next_vdsl = wr_data[`RTC_C2_VDSL];
          next_vdet = vdet & wr_data[`RTC_C2_VDET];
          next_osc_halt_monitor_n = wr_data[`RTC_C2_XST];
          next_power_up_flag = power_up_flag & wr_data[`RTC_C2_PON];
          next_clkout_disable_a = wr_data[`RTC_C2_CLKOUT_DISABLE_A];
          if (level_mode && !wr_data[`RTC_C2_PERIODIC_IRQ_FLAG])
            next_level_flag = 1'b0;
          next_weekly_alarm_flag = weekly_alarm_flag &
            wr_data[`RTC_C2_WEEKLY_ALARM_FLAG];
          next_daily_alarm_flag = daily_alarm_flag & wr_data[`RTC_C2_DAILY_ALARM_FLAG];
        end
        default: next_adjust = adjust;
      endcase
    end
    // Hardware set wins over a same-cycle clear
    if (period_ev) next_level_flag = 1'b1;
    if (alarm_hit[0]) next_weekly_alarm_flag = 1'b1;
    if (alarm_hit[1]) next_daily_alarm_flag = 1'b1;
    if (pon_hold) begin
      next_adjust = 7'h00;
      next_ctrl1 = `RTC_BYTE_RESET;
      next_vdsl = 1'b0;
      next_vdet = 1'b0;
      next_clkout_disable_a = 1'b0;
      next_level_flag = 1'b0;
      next_weekly_alarm_flag = 1'b0;
      next_daily_alarm_flag = 1'b0;
    end
    next_slow_clock_out = xtal_s2 &
      ~(next_clkout_disable_a & next_ctrl1[`RTC_C1_CLKOUT_DISABLE_B]);
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      power_up_flag <= 1'b1;
      prescaler <= 15'h0000;
      seconds <= 7'h00;
      minutes <= 7'h00;
      hours <= 6'h00;
      snap_sec <= 7'h00;
      snap_min <= 7'h00;
      snap_hour <= 6'h00;
      adjust <= 7'h00;
      ctrl1 <= `RTC_BYTE_RESET;
      osc_halt_monitor_n <= 1'b0;
      vdsl <= 1'b0;
      vdet <= 1'b0;
      clkout_disable_a <= 1'b0;
      level_flag <= 1'b0;
      weekly_alarm_flag <= 1'b0;
      daily_alarm_flag <= 1'b0;
      slow_clock_out <= 1'b0;
      day_carry <= 1'b0;
    end else begin
      power_up_flag <= next_power_up_flag;
      prescaler <= next_prescaler;
      seconds <= next_seconds;
      minutes <= next_minutes;
      hours <= next_hours;
      snap_sec <= next_snap_sec;
      snap_min <= next_snap_min;
      snap_hour <= next_snap_hour;
      adjust <= next_adjust;
      ctrl1 <= next_ctrl1;
      osc_halt_monitor_n <= next_osc_halt_monitor_n;
      vdsl <= next_vdsl;
      vdet <= next_vdet;
      clkout_disable_a <= next_clkout_disable_a;
      level_flag <= next_level_flag;
      weekly_alarm_flag <= next_weekly_alarm_flag;
      daily_alarm_flag <= next_daily_alarm_flag;
      slow_clock_out <= next_slow_clock_out;
      day_carry <= next_day_carry;
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence minute_rollover;
    sec_inc && seconds == `RTC_BCD_59;
  endsequence

  a_pon_sticky: assert property (pon_hold |=> power_up_flag)
    else $error("power-up flag dropped without a clearing write");
  a_pon_clears: assert property (pon_hold |=>
    ctrl1 == 8'h00 && adjust == 7'h00 && irq_pin_a_n && irq_pin_b_n)
    else $error("power-up flag did not clear control bits");
  a_pon_write: assert property (power_up_flag && !pon_hold |=>
    !power_up_flag)
    else $error("writing 0 did not clear the power-up flag");
  a_clkout_gate: assert property (
    $past(clkout_disable_a && clkout_disable_b) && clkout_disable_a &&
    clkout_disable_b |-> !slow_clock_out)
    else $error("clock output active while both disables set");
  a_periodic_irq_flag_pin: assert property (periodic_active |-> !irq_pin_a_n)
    else $error("periodic flag set while pin A high");
  a_level_clear: assert property (level_mode && wr_pulse &&
    reg_addr == `RTC_ADDR_CTRL2 && !wr_data[`RTC_C2_PERIODIC_IRQ_FLAG] && !period_ev
    |=> !level_flag)
    else $error("periodic flag not cleared by write of 0");
  a_alarm_gate: assert property (!weekly_alarm_enable |->
    irq_pin_b_n &&
    (rd_data[`RTC_C2_WEEKLY_ALARM_FLAG] == 1'b0 || reg_addr != `RTC_ADDR_CTRL2))
    else $error("weekly alarm flag visible while disabled");
  a_sec_wrap: assert property ((minute_rollover and !wr_pulse) |=>
    seconds == 7'h00 && $changed(minutes))
    else $error("seconds did not wrap with a carry");
  a_sec_write: assert property (wr_pulse &&
    reg_addr == `RTC_ADDR_SECONDS |=> prescaler == 15'h0000)
    else $error("seconds write left the prescaler running");
  a_minute_irq: assert property ((ct_mode == ct_min && !pon_hold) and
    minute_rollover |=> level_flag && !irq_pin_a_n)
    else $error("minute interrupt missed at 00 seconds");
  a_hour_carry: assert property (hour_ev && mode24 &&
    hours == `RTC_HOUR_23 && !wr_pulse |=> day_carry && hours == 6'h00)
    else $error("midnight carry missing");
endmodule // rtc_flags_and_time_counters

`default_nettype wire

// file: bench/host_bus_model.sv
/* Two-wire bus host: START, bytes, STOP. Assumes SDA has a pull-up. */
`timescale 1ns/1ns
`default_nettype none
`include "rtc_params.svh"
module host_bus_model (
  input wire logic clk,
  input wire logic sda_oe,
  output logic scl,
  output logic sda
);
  logic low = 1'b0;
  // Released line floats high
  assign sda = !(sda_oe || low);
  initial scl = 1'b1;
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic bit_io(input logic b, output logic r);
    low = !b;
    hold(6);
    scl = 1'b1;
    hold(6);
    r = sda;
    scl = 1'b0;
    hold(2);
  endtask
  task automatic byte_io(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
  endtask
  // START when s is 1, else STOP
  task automatic cond(input logic s);
    low = !s;
    hold(2);
    scl = 1'b1;
    hold(6);
    low = s;
    hold(6);
    scl = !s;
    hold(2);
  endtask
  task automatic access(input logic rd, input logic [3:0] a,
      input logic [7:0] d, output logic [7:0] q, output logic nak);
    logic [8:0] r0, r1, r2, r3;
    cond(1'b1);
    byte_io({`RTC_DEV_ADDR, 2'b01}, r0);
    byte_io({4'h0, a, 1'b1}, r1);
    if (rd) begin
      cond(1'b1);
      byte_io({`RTC_DEV_ADDR, 2'b11}, r2);
    end
    byte_io(rd ? 9'h1FF : {d, 1'b1}, r3);
    cond(1'b0);
    q = r3[8:1];
    nak = r0[0] | r1[0] | (rd ? r2[0] : r3[0]);
  endtask
endmodule // host_bus_model
`default_nettype wire

// file: bench/test_rtc_flags_and_time_counters.sv
/* Flag and time-counter bench. Assumes host_bus_model for register access. */
`timescale 1ns/1ns
`default_nettype none
module test_rtc_flags_and_time_counters;
  logic clk = 1'b0, nrst = 1'b0, xtal = 1'b0, xrun = 1'b0;
  logic wk = 1'b0, dy = 1'b0, last, nak;
  logic [7:0] q;
  logic [31:0] v;
  wire logic scl, sda, sdo, sda_oe, slow, pa_n, pb_n, dcar;
  int n_fail = 0, cmp_count = 0, cyc = 0, t0, edges, seed = 88319, mdl [16];
  initial forever #20 clk = !clk;
  // Crystal stand-in toggles each clock so one second is 65536 cycles
  always @(posedge clk) #1 xtal = xrun & !xtal;
  rtc_flags_and_time_counters u_dut (.clk(clk), .nrst(nrst),
    .scl_in(scl), .sda_in(sda), .sda_out(sdo), .sda_oe(sda_oe),
    .xtal_in(xtal), .weekly_alarm_match(wk), .daily_alarm_match(dy),
    .slow_clock_out(slow), .irq_pin_a_n(pa_n), .irq_pin_b_n(pb_n),
    .day_carry(dcar));
  host_bus_model u_host (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    last <= slow;
    if (slow !== last) edges++;
    if (cyc == 95000) begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    u_host.access(1'b0, a, d, q, nak);
    chk("ack", 8'h00, {7'h00, nak});
    case (a)
      4'h0, 4'h1, 4'h7: mdl[a] = d & 8'h7F;
      4'h2: mdl[a] = d & 8'h3F;
      4'hE: mdl[a] = d;
      4'hF: mdl[a] = d & 8'hA8 | mdl[a] & d & 8'h57;
      default: ;
    endcase
    if (mdl[15][4]) begin
      mdl[15] &= 8'h30;
      mdl[14] = 0;
      mdl[7] = 0;
    end
    mdl[15] &= ~{6'h0, !mdl[14][7], !mdl[14][6]};
  endtask
  task automatic rd(input logic [3:0] a);
    u_host.access(1'b1, a, 8'h00, q, nak);
    chk("register", mdl[a][7:0], q);
  endtask
  initial begin
    mdl[15] = 8'h10;
    tick(3);
    nrst = 1'b1;
    tick(3);
    chk("pins", 8'h03, {5'h0, sdo, pa_n, pb_n});
    rd(4'hF);
    wr(4'hE, 8'hD4);
    wr(4'h7, 8'h15);
    rd(4'hE);
    rd(4'h7);
    wr(4'hF, 8'h10);
    rd(4'hF);
    wr(4'hF, 8'h00);
    rd(4'hF);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      if (i != 2) wr(i[3:0], {v[7], 3'(v[6:4] % 6), 4'(v[3:0] % 10)});
      rd(i[3:0]);
    end
    wr(4'hE, 8'hC0);
    wk = 1'b1;
    dy = 1'b1;
    tick(1500);
    chk("pins early", 8'h03, {6'h0, pa_n, pb_n});
    tick(60);
    chk("pins late", 8'h00, {6'h0, pa_n, pb_n});
    wk = 1'b0;
    dy = 1'b0;
    mdl[15] = 8'h03;
    rd(4'hF);
    wr(4'hF, 8'h03);
    wr(4'hF, 8'h01);
    rd(4'hF);
    chk("pins", 8'h01, {6'h0, pa_n, pb_n});
    wr(4'hE, 8'h00);
    rd(4'hF);
    xrun = 1'b1;
    wr(4'hE, 8'h10);
    edges = 0;
    tick(30);
    chk("clkout runs", 8'h01, {7'h0, edges > 10});
    wr(4'hF, 8'h08);
    edges = 0;
    tick(30);
    chk("clkout held", 8'h00, {7'h0, edges > 0 || slow !== 1'b0});
    wr(4'hE, 8'h25);
    wr(4'h2, 8'hE3);
    wr(4'h1, 8'h59);
    wr(4'h0, 8'h59);
    t0 = cyc;
    while (dcar !== 1'b1 && cyc - t0 < 65600) tick(1);
    chk("day carry", 8'h01, {7'h0, dcar});
    chk("second length", 8'h01, {7'h0, cyc - t0 > 65400});
    chk("pin a", 8'h00, {7'h0, pa_n});
    mdl[0] = 0;
    mdl[1] = 0;
    mdl[2] = 0;
    mdl[15] = 8'h0C;
    for (int i = 0; i < 3; i++) rd(i[3:0]);
    rd(4'hF);
    wr(4'hF, 8'h08);
    rd(4'hF);
    chk("pin a", 8'h01, {7'h0, pa_n});
    wr(4'hE, 8'h01);
    mdl[15] = 8'h0C;
    rd(4'hF);
    chk("pin a low", 8'h00, {7'h0, pa_n});
    wrap_up();
  end
endmodule // test_rtc_flags_and_time_counters
`default_nettype wire
